// ---- src/cag_cfg.svh ----
`ifndef CAG_CFG_SVH
`define CAG_CFG_SVH

// ****************************************************************
// Address map constants.
// ****************************************************************
`define CAG_RESET_PC        16'h0000
`define CAG_RESET_SP        16'h0000
`define CAG_RESET_GPR       8'h00
`define CAG_TABLE_BASE      16'h0040
`define CAG_SHORT_SPLIT     8'h20
`define CAG_SHORT_PAGE      7'h7F
`define CAG_SFR_PAGE        8'hFF
`define CAG_PRODUCT_ADDR    16'hFF14
`define CAG_FAST_RAM_LO     16'hFB00
`define CAG_FAST_RAM_HI     16'hFEFF

// ****************************************************************
// Register file layout: byte registers and their pairs.
// ****************************************************************
`define CAG_GPR_COUNT       8
`define CAG_ACC_LO_IDX      3'h0
`define CAG_ACC_HI_IDX      3'h1
`define CAG_IDX1_LO_IDX     3'h4
`define CAG_IDX1_HI_IDX     3'h5
`define CAG_BASE_LO_IDX     3'h6
`define CAG_BASE_HI_IDX     3'h7

`endif

// ---- src/cag_pkg.sv ----
`default_nettype none

package cag_pkg;

    // ****************************************************************
    // Branch kinds, operand modes and sequencer states.
    // ****************************************************************
    typedef enum logic [2:0] {
        CAG_BR_SEQ = 3'b000,
        CAG_BR_REL = 3'b001,
        CAG_BR_IMM = 3'b010,
        CAG_BR_TBL = 3'b011,
        CAG_BR_REG = 3'b100
    } cag_br_kind_e;

    typedef enum logic [2:0] {
        CAG_OP_DIRECT = 3'b000,
        CAG_OP_SHORT  = 3'b001,
        CAG_OP_SFR    = 3'b010,
        CAG_OP_REG    = 3'b011,
        CAG_OP_IND_DE = 3'b100,
        CAG_OP_IND_HL = 3'b101,
        CAG_OP_BASED  = 3'b110
    } cag_op_mode_e;

    typedef enum logic [0:0] {
        CAG_ST_IDLE     = 1'b0,
        CAG_ST_TBL_WAIT = 1'b1
    } cag_state_e;

    // Every address sum folds modulo 65536; the carry is simply dropped.
    function automatic logic [15:0] cag_add16(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        return sum[15:0];
    endfunction

endpackage

`default_nettype wire

// ---- src/cag_branch_target.sv ----
`default_nettype none

module cag_branch_target
    import cag_pkg::*;
(
    input  wire logic [15:0]  pc,
    input  wire logic [2:0]   instr_len,
    input  wire cag_br_kind_e kind,
    input  wire logic         taken,
    input  wire logic [7:0]   branch_displacement,
    input  wire logic [15:0]  imm16,
    input  wire logic [15:0]  accumulator_pair,
    output logic      [15:0]  target
);

    wire logic [15:0] follow_addr;
    wire logic [15:0] rel_addr;

    // ****************************************************************
    // Target selection.
    // ****************************************************************
    assign follow_addr = cag_add16(pc, {13'h0000, instr_len});
    assign rel_addr    = cag_add16(follow_addr, {{8{branch_displacement[7]}}, branch_displacement});

    // A conditional branch not taken simply falls through.
    assign target = (kind == CAG_BR_REL && taken) ? rel_addr :
                    (kind == CAG_BR_IMM)          ? imm16 :
                    (kind == CAG_BR_REG)          ? accumulator_pair :
                                                    follow_addr;

endmodule // cag_branch_target

`default_nettype wire

// ---- src/cag_operand_ea.sv ----
`default_nettype none

`include "cag_cfg.svh"

module cag_operand_ea
    import cag_pkg::*;
(
    input  wire logic [2:0]  mode,
    input  wire logic        word,
    input  wire logic [7:0]  imm8,
    input  wire logic [15:0] imm16,
    input  wire logic [15:0] index_pair_one,
    input  wire logic [15:0] base_pair,
    output logic      [15:0] ea,
    output logic             misalign,
    output logic             width_refused
);

    wire logic        low_page;
    wire logic [15:0] short_addr;
    wire logic [15:0] sfr_addr;
    wire logic [15:0] based_addr;

    // ****************************************************************
    // Effective address per mode.
    // ****************************************************************
    assign low_page   = imm8 < `CAG_SHORT_SPLIT;
    assign short_addr = {`CAG_SHORT_PAGE, low_page, imm8};
    assign sfr_addr   = {`CAG_SFR_PAGE, imm8};
    assign based_addr = cag_add16(base_pair, {8'h00, imm8});

    assign ea = (mode == CAG_OP_DIRECT) ? imm16 :
                (mode == CAG_OP_SHORT)  ? short_addr :
                (mode == CAG_OP_SFR)    ? sfr_addr :
                (mode == CAG_OP_IND_DE) ? index_pair_one :
                (mode == CAG_OP_IND_HL) ? base_pair :
                (mode == CAG_OP_BASED)  ? based_addr :
                                          16'h0000;

    // A word short direct operand must be even; odd ones are flagged.
    assign misalign      = word && (mode == CAG_OP_SHORT) && ea[0];
    // The product register only takes word access through short direct.
    assign width_refused = word && (ea == `CAG_PRODUCT_ADDR) && (mode != CAG_OP_SHORT);

endmodule // cag_operand_ea

`default_nettype wire

// ---- src/cag_addr_gen.sv ----

`default_nettype none

`include "cag_cfg.svh"

module cag_addr_gen
    import cag_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         br_req,
    input  wire cag_br_kind_e br_kind,
    input  wire logic         br_taken,
    input  wire logic [2:0]   instr_len,
    input  wire logic [7:0]   branch_displacement,
    input  wire logic [15:0]  br_imm16,
    input  wire logic [7:0]   table_call_instruction,
    output logic              br_ready,
    output logic      [15:0]  program_counter,
    output logic              tbl_rd_req,
    output logic      [15:0]  tbl_addr,
    input  wire logic         tbl_ack,
    input  wire logic [15:0]  tbl_rdata,
    input  wire logic         op_req,
    input  wire cag_op_mode_e op_mode,
    input  wire logic         op_word,
    input  wire logic [7:0]   op_imm8,
    input  wire logic [15:0]  op_imm16,
    input  wire logic [2:0]   op_reg_sel,
    output logic              op_valid,
    output logic      [15:0]  op_addr,
    output logic      [7:0]   op_reg_data,
    output logic              op_misalign,
    output logic              op_width_refused,
    input  wire logic         gpr_we,
    input  wire logic [2:0]   gpr_wsel,
    input  wire logic [7:0]   gpr_wdata,
    input  wire logic         stk_req,
    input  wire logic         stk_pop,
    output logic              stk_valid,
    output logic      [15:0]  stk_addr,
    output logic              stk_out_of_range,
    input  wire logic         sp_we,
    input  wire logic [15:0]  sp_wdata,
    output logic      [15:0]  stack_pointer
);

    // ****************************************************************
    // Reset release.
    // ****************************************************************
    // The reset is applied at once but released through two flops so
    // that every register below leaves reset on the same clean edge.
    logic [1:0] rst_sync;
    wire logic  rst_core_n;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_core_n = rst_sync[1];

    // ****************************************************************
    // General-purpose byte registers.
    // ****************************************************************
    logic [7:0]       gpr [0:`CAG_GPR_COUNT-1];
    wire logic [15:0] accumulator_pair;
    wire logic [15:0] index_pair_one;
    wire logic [15:0] base_pair;

    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            for (int i = 0; i < `CAG_GPR_COUNT; i++) begin
                gpr[i] <= `CAG_RESET_GPR;
            end
        end else if (gpr_we) begin
            gpr[gpr_wsel] <= gpr_wdata;
        end
    end

    assign accumulator_pair = {gpr[`CAG_ACC_HI_IDX], gpr[`CAG_ACC_LO_IDX]};
    assign index_pair_one   = {gpr[`CAG_IDX1_HI_IDX], gpr[`CAG_IDX1_LO_IDX]};
    assign base_pair        = {gpr[`CAG_BASE_HI_IDX], gpr[`CAG_BASE_LO_IDX]};

    // ****************************************************************
    // Program counter sequencing.
    // ****************************************************************
    cag_state_e       state;
    cag_state_e       next_state;
    wire logic [15:0] br_target;
    wire logic [15:0] table_entry;
    wire logic        br_take;
    wire logic        tbl_start;
    wire logic        tbl_done;

    cag_branch_target u_branch (
        .pc                  (program_counter),
        .instr_len           (instr_len),
        .kind                (br_kind),
        .taken               (br_taken),
        .branch_displacement (branch_displacement),
        .imm16               (br_imm16),
        .accumulator_pair    (accumulator_pair),
        .target              (br_target)
    );

    // While a table word is outstanding, new branch requests are ignored.
    assign br_ready  = (state == CAG_ST_IDLE);
    assign br_take   = br_req && br_ready;
    assign tbl_start = br_take && (br_kind == CAG_BR_TBL);
    assign tbl_done  = (state == CAG_ST_TBL_WAIT) && tbl_ack;

    // Table entries are words, so the five-bit index is doubled.
    assign table_entry = cag_add16(`CAG_TABLE_BASE,
                                   {10'h000, table_call_instruction[5:1], 1'b0});

    always_comb begin
        next_state = state;
        unique case (state)
            CAG_ST_IDLE: begin
                if (tbl_start) begin
                    next_state = CAG_ST_TBL_WAIT;
                end
            end
            CAG_ST_TBL_WAIT: begin
                if (tbl_ack) begin
                    next_state = CAG_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            state <= CAG_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            program_counter <= `CAG_RESET_PC;
        end else if (tbl_done) begin
            program_counter <= tbl_rdata;
        end else if (br_take && br_kind != CAG_BR_TBL) begin
            program_counter <= br_target;
        end
    end

    // The table read request stands until the memory acknowledges it.
    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            tbl_rd_req <= 1'b0;
            tbl_addr   <= 16'h0000;
        end else if (tbl_start) begin
            tbl_rd_req <= 1'b1;
            tbl_addr   <= table_entry;
        end else if (tbl_done) begin
            tbl_rd_req <= 1'b0;
        end
    end

    // ****************************************************************
    // Operand addressing.
    // ****************************************************************
    wire logic [15:0] ea;
    wire logic        ea_misalign;
    wire logic        ea_width_refused;
    wire logic        op_is_reg;

    cag_operand_ea u_operand (
        .mode           (op_mode),
        .word           (op_word),
        .imm8           (op_imm8),
        .imm16          (op_imm16),
        .index_pair_one (index_pair_one),
        .base_pair      (base_pair),
        .ea             (ea),
        .misalign       (ea_misalign),
        .width_refused  (ea_width_refused)
    );

    assign op_is_reg = (op_mode == CAG_OP_REG);

    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            op_valid         <= 1'b0;
            op_addr          <= 16'h0000;
            op_reg_data      <= 8'h00;
            op_misalign      <= 1'b0;
            op_width_refused <= 1'b0;
        end else begin
            op_valid <= op_req;
            if (op_req) begin
                op_addr          <= ea;
                op_reg_data      <= op_is_reg ? gpr[op_reg_sel] : 8'h00;
                op_misalign      <= ea_misalign;
                op_width_refused <= ea_width_refused;
            end
        end
    end

    // ****************************************************************
    // Stack addressing.
    // ****************************************************************
    // A push writes below the current top; a pop reads the top and then
    // moves the pointer up, so both share one adder per direction.
    wire logic [15:0] sp_dec;
    wire logic [15:0] sp_inc;
    wire logic [15:0] stk_target;
    wire logic        stk_in_ram;

    assign sp_dec     = cag_add16(stack_pointer, 16'hFFFF);
    assign sp_inc     = cag_add16(stack_pointer, 16'h0001);
    assign stk_target = stk_pop ? stack_pointer : sp_dec;
    assign stk_in_ram = (stk_target >= `CAG_FAST_RAM_LO) &&
                        (stk_target <= `CAG_FAST_RAM_HI);

    // A stack request in the same cycle as a pointer load wins, since
    // the decoder never issues both and the stack move must not be lost.
    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            stack_pointer <= `CAG_RESET_SP;
        end else if (stk_req) begin
            stack_pointer <= stk_pop ? sp_inc : sp_dec;
        end else if (sp_we) begin
            stack_pointer <= sp_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            stk_valid        <= 1'b0;
            stk_addr         <= 16'h0000;
            stk_out_of_range <= 1'b0;
        end else begin
            stk_valid <= stk_req;
            if (stk_req) begin
                stk_addr         <= stk_target;
                stk_out_of_range <= !stk_in_ram;
            end
        end
    end

endmodule // cag_addr_gen

`default_nettype wire

// ---- tb/cag_mem_model.sv ----
`default_nettype none
// **********************************
// Table memory seen by the generator.
// **********************************
module cag_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        slow,
    input  wire logic        tbl_rd_req,
    input  wire logic [15:0] tbl_addr,
    output logic             tbl_ack,
    output logic      [15:0] tbl_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt;
    // The data lines toggle between answers, so a stale word is never taken for a fresh one.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 3'h0;
            tbl_ack <= 1'h0;
            tbl_rdata <= 16'h0;
        end else begin
            tbl_ack <= 1'h0;
            tbl_rdata <= ~tbl_rdata;
            if (tbl_rd_req && !tbl_ack) begin
                if (cnt == (slow ? 3'h5 : 3'h0)) begin
                    tbl_ack <= 1'h1;
                    tbl_rdata <= ~tbl_addr;
                    cnt <= 3'h0;
                end else begin
                    cnt <= cnt + 3'h1;
                end
            end
        end
    end
endmodule // cag_mem_model
`default_nettype wire

// ---- tb/cag_addr_gen_chk.sv ----
`default_nettype none
// **********************************
// Port checks of the address generator.
// **********************************
module cag_addr_gen_chk
    import cag_pkg::*;
(
    input wire logic         ref_clk,
    input wire logic         rst_n,
    input wire logic         br_req,
    input wire cag_br_kind_e br_kind,
    input wire logic         br_taken,
    input wire logic [2:0]   instr_len,
    input wire logic [7:0]   branch_displacement,
    input wire logic [15:0]  br_imm16,
    input wire logic [7:0]   table_call_instruction,
    input wire logic         br_ready,
    input wire logic [15:0]  program_counter,
    input wire logic         tbl_rd_req,
    input wire logic [15:0]  tbl_addr,
    input wire logic         tbl_ack,
    input wire logic [15:0]  tbl_rdata,
    input wire logic         op_req,
    input wire cag_op_mode_e op_mode,
    input wire logic [7:0]   op_imm8,
    input wire logic [15:0]  op_addr,
    input wire logic         stk_req,
    input wire logic         stk_pop,
    input wire logic [15:0]  stk_addr,
    input wire logic [15:0]  stack_pointer
);
    timeunit 1ns;
    timeprecision 1ps;
    logic br_go;
    assign br_go = br_req && br_ready;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    chk_seq_step: assert property (br_go && (br_kind == CAG_BR_SEQ || br_kind == CAG_BR_REL && !br_taken)
        |=> program_counter == $past(program_counter) + $past(instr_len)) else $error("step target wrong");
    chk_rel_target: assert property (br_go && br_kind == CAG_BR_REL && br_taken
        |=> program_counter == $past(program_counter) + $past(instr_len)
            + {{8{$past(branch_displacement[7])}}, $past(branch_displacement)}) else $error("relative target wrong");
    chk_imm_load: assert property (br_go && br_kind == CAG_BR_IMM
        |=> program_counter == $past(br_imm16)) else $error("immediate target wrong");
    chk_table_slot: assert property (br_go && br_kind == CAG_BR_TBL
        |=> tbl_rd_req && !br_ready && tbl_addr == {9'h0, 1'h1, $past(table_call_instruction[5:1]), 1'h0})
        else $error("table slot wrong");
    chk_table_load: assert property (tbl_rd_req && tbl_ack
        |=> br_ready && !tbl_rd_req && program_counter == $past(tbl_rdata)) else $error("table word lost");
    chk_short_fill: assert property (op_req && op_mode == CAG_OP_SHORT
        |=> op_addr == {7'h7F, $past(op_imm8) < 8'h20, $past(op_imm8)}) else $error("short address wrong");
    chk_sfr_page: assert property (op_req && op_mode == CAG_OP_SFR
        |=> op_addr == {8'hFF, $past(op_imm8)}) else $error("page address wrong");
    chk_push_predec: assert property (stk_req && !stk_pop
        |=> stk_addr == $past(stack_pointer) - 16'h1 && stack_pointer == stk_addr) else $error("push wrong");
    chk_pop_postinc: assert property (stk_req && stk_pop
        |=> stk_addr == $past(stack_pointer) && stack_pointer == $past(stack_pointer) + 16'h1)
        else $error("pop wrong");
endmodule // cag_addr_gen_chk

bind cag_addr_gen cag_addr_gen_chk u_chk (.ref_clk, .rst_n, .br_req, .br_kind, .br_taken, .instr_len,
    .branch_displacement, .br_imm16, .table_call_instruction, .br_ready, .program_counter, .tbl_rd_req,
    .tbl_addr, .tbl_ack, .tbl_rdata, .op_req, .op_mode, .op_imm8, .op_addr, .stk_req, .stk_pop, .stk_addr,
    .stack_pointer);
`default_nettype wire

// ---- tb/test_cag_addr_gen.sv ----
`default_nettype none
module test_cag_addr_gen
    import cag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        cag_op_mode_e mode;
        logic         word;
        logic [7:0]   imm8;
        logic [15:0]  imm16;
        logic [2:0]   sel;
        logic [15:0]  addr;
        logic [7:0]   data;
        logic [1:0]   flags;
    } cag_op_row_s;
    typedef struct packed {
        cag_br_kind_e kind;
        logic         taken;
        logic [2:0]   len;
        logic [7:0]   disp;
        logic [15:0]  imm;
        logic [15:0]  pc;
    } cag_br_row_s;
    logic         ref_clk, rst_n, br_req, br_taken, op_req, op_word, gpr_we, stk_req, stk_pop, sp_we, slow;
    logic         br_ready, tbl_rd_req, tbl_ack, op_valid, op_misalign, op_width_refused, stk_valid;
    logic         stk_out_of_range;
    logic [2:0]   instr_len, op_reg_sel, gpr_wsel;
    logic [7:0]   branch_displacement, table_call_instruction, op_imm8, gpr_wdata, op_reg_data;
    logic [15:0]  br_imm16, op_imm16, sp_wdata, program_counter, tbl_addr, tbl_rdata, op_addr, stk_addr;
    logic [15:0]  stack_pointer;
    cag_br_kind_e br_kind;
    cag_op_mode_e op_mode;
    int           n_fail = 0;
    int           num_checks = 0;
    logic [7:0]   gv [8] = '{8'hEF, 8'hBE, 8'hC2, 8'hB3, 8'h34, 8'h12, 8'hF0, 8'hFF};
    cag_op_row_s  ops [12] = '{
        '{CAG_OP_DIRECT, 1'h0, 8'h0, 16'hFE00, 3'h0, 16'hFE00, 8'h0, 2'h0},
        '{CAG_OP_DIRECT, 1'h1, 8'h0, 16'hFF14, 3'h0, 16'hFF14, 8'h0, 2'h1},
        '{CAG_OP_SHORT, 1'h0, 8'h20, 16'h0, 3'h0, 16'hFE20, 8'h0, 2'h0},
        '{CAG_OP_SHORT, 1'h0, 8'h1F, 16'h0, 3'h0, 16'hFF1F, 8'h0, 2'h0},
        '{CAG_OP_SHORT, 1'h1, 8'h14, 16'h0, 3'h0, 16'hFF14, 8'h0, 2'h0},
        '{CAG_OP_SHORT, 1'h1, 8'h21, 16'h0, 3'h0, 16'hFE21, 8'h0, 2'h2},
        '{CAG_OP_SFR, 1'h0, 8'h00, 16'h0, 3'h0, 16'hFF00, 8'h0, 2'h0},
        '{CAG_OP_SFR, 1'h1, 8'h14, 16'h0, 3'h0, 16'hFF14, 8'h0, 2'h1},
        '{CAG_OP_IND_DE, 1'h0, 8'h0, 16'h0, 3'h0, 16'h1234, 8'h0, 2'h0},
        '{CAG_OP_IND_HL, 1'h0, 8'h0, 16'h0, 3'h0, 16'hFFF0, 8'h0, 2'h0},
        '{CAG_OP_BASED, 1'h0, 8'hF0, 16'h0, 3'h0, 16'h00E0, 8'h0, 2'h0},
        '{CAG_OP_REG, 1'h0, 8'h0, 16'h0, 3'h3, 16'h0, 8'hB3, 2'h0}
    };
    cag_br_row_s  brs [8] = '{
        '{CAG_BR_SEQ, 1'h0, 3'h3, 8'h0, 16'h0, 16'h0003},
        '{CAG_BR_IMM, 1'h0, 3'h3, 8'h0, 16'h1000, 16'h1000},
        '{CAG_BR_REL, 1'h1, 3'h2, 8'hFE, 16'h0, 16'h1000},
        '{CAG_BR_REL, 1'h1, 3'h2, 8'h80, 16'h0, 16'h0F82},
        '{CAG_BR_REL, 1'h0, 3'h2, 8'h80, 16'h0, 16'h0F84},
        '{CAG_BR_IMM, 1'h0, 3'h3, 8'h0, 16'hFFF0, 16'hFFF0},
        '{CAG_BR_REL, 1'h1, 3'h2, 8'h7F, 16'h0, 16'h0071},
        '{CAG_BR_REG, 1'h0, 3'h1, 8'h0, 16'h0, 16'hBEEF}
    };

    cag_addr_gen u_dut (
        .ref_clk, .rst_n, .br_req, .br_kind, .br_taken, .instr_len, .branch_displacement, .br_imm16,
        .table_call_instruction, .br_ready, .program_counter, .tbl_rd_req, .tbl_addr, .tbl_ack, .tbl_rdata,
        .op_req, .op_mode, .op_word, .op_imm8, .op_imm16, .op_reg_sel, .op_valid, .op_addr, .op_reg_data,
        .op_misalign, .op_width_refused, .gpr_we, .gpr_wsel, .gpr_wdata, .stk_req, .stk_pop, .stk_valid,
        .stk_addr, .stk_out_of_range, .sp_we, .sp_wdata, .stack_pointer
    );
    cag_mem_model u_mem (.ref_clk, .rst_n, .slow, .tbl_rd_req, .tbl_addr, .tbl_ack, .tbl_rdata);

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic do_br(input cag_br_kind_e k, input logic t, input logic [2:0] n, input logic [7:0] d,
                         input logic [15:0] imm);
        @(negedge ref_clk);
        br_req = 1'h1;
        br_kind = k;
        br_taken = t;
        instr_len = n;
        branch_displacement = d;
        br_imm16 = imm;
        @(negedge ref_clk);
        br_req = 1'h0;
    endtask
    // The step request lands while the table word is awaited and must be ignored.
    task automatic tbl_call(input logic [7:0] opc, input logic s, input logic [15:0] ea, input logic [15:0] old);
        slow = s;
        table_call_instruction = opc;
        do_br(CAG_BR_TBL, 1'h0, 3'h1, 8'h0, 16'h0);
        check("br_ready", 16'h0, br_ready);
        check("tbl_addr", ea, tbl_addr);
        do_br(CAG_BR_SEQ, 1'h0, 3'h3, 8'h0, 16'h0);
        if (s) check("program_counter", old, program_counter);
        for (int i = 0; i < 20 && br_ready !== 1'h1; i++) @(negedge ref_clk);
        check("program_counter", ~ea, program_counter);
    endtask
    task automatic do_op(input cag_op_row_s r);
        @(negedge ref_clk);
        op_req = 1'h1;
        op_mode = r.mode;
        op_word = r.word;
        op_imm8 = r.imm8;
        op_imm16 = r.imm16;
        op_reg_sel = r.sel;
        @(negedge ref_clk);
        op_req = 1'h0;
        check("op_valid", 16'h1, op_valid);
        check("op_addr", r.addr, op_addr);
        check("op_reg_data", r.data, op_reg_data);
        check("op_flags", r.flags, {op_misalign, op_width_refused});
    endtask
    task automatic do_stk(input logic pop, input logic [15:0] a, input logic [15:0] sp, input logic oor);
        @(negedge ref_clk);
        stk_req = 1'h1;
        stk_pop = pop;
        @(negedge ref_clk);
        stk_req = 1'h0;
        check("stk_valid", 16'h1, stk_valid);
        check("stk_addr", a, stk_addr);
        check("stack_pointer", sp, stack_pointer);
        check("stk_out_of_range", oor, stk_out_of_range);
    endtask
    task automatic load_sp(input logic [15:0] v);
        @(negedge ref_clk);
        sp_we = 1'h1;
        sp_wdata = v;
        @(negedge ref_clk);
        sp_we = 1'h0;
    endtask

    initial begin
        ref_clk = 1'h0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (2000) @(posedge ref_clk);
        n_fail++;
        give_verdict();
    end
    initial begin
        {rst_n, br_req, br_taken, op_req, op_word, gpr_we, stk_req, stk_pop, sp_we, slow} = '0;
        {instr_len, op_reg_sel, gpr_wsel, branch_displacement, table_call_instruction, op_imm8, gpr_wdata} = '0;
        {br_imm16, op_imm16, sp_wdata} = '0;
        br_kind = CAG_BR_SEQ;
        op_mode = CAG_OP_DIRECT;
        repeat (6) @(negedge ref_clk);
        rst_n = 1'h1;
        repeat (3) @(negedge ref_clk);
        foreach (gv[i]) begin
            @(negedge ref_clk);
            gpr_we = 1'h1;
            gpr_wsel = 3'(i);
            gpr_wdata = gv[i];
        end
        @(negedge ref_clk);
        gpr_we = 1'h0;
        foreach (ops[i]) do_op(ops[i]);
        done("operand");
        foreach (brs[i]) begin
            do_br(brs[i].kind, brs[i].taken, brs[i].len, brs[i].disp, brs[i].imm);
            check("program_counter", brs[i].pc, program_counter);
        end
        done("branch");
        tbl_call(8'h3E, 1'h0, 16'h007E, 16'h0);
        tbl_call(8'hC1, 1'h1, 16'h0040, 16'hFF81);
        done("table call");
        load_sp(16'hFE00);
        do_stk(1'h0, 16'hFDFF, 16'hFDFF, 1'h0);
        do_stk(1'h1, 16'hFDFF, 16'hFE00, 1'h0);
        load_sp(16'hFB00);
        do_stk(1'h0, 16'hFAFF, 16'hFAFF, 1'h1);
        done("stack");
        rst_n = 1'h0;
        @(negedge ref_clk);
        check("program_counter", 16'h0, program_counter);
        check("stack_pointer", 16'h0, stack_pointer);
        check("br_ready", 16'h1, br_ready);
        rst_n = 1'h1;
        repeat (3) @(negedge ref_clk);
        do_br(CAG_BR_SEQ, 1'h0, 3'h1, 8'h0, 16'h0);
        check("program_counter", 16'h1, program_counter);
        done("reset");
        give_verdict();
    end
endmodule // test_cag_addr_gen
`default_nettype wire
